// ===== dcf_fifo.sv
// dual clock fifo core: pin sampling, pointers, flags, offset registers
`timescale 1ns/1ps
// Functional notes
// - reset empties fifo, empty flag low, all flags valid right after reset.
// - data outputs read zero after reset releases.
// - dual enable mode: write when enable1 low, enable2 high, not full.
// - each read clock edge with both read enables low shows next word.
// - output enable high floats data pins; low drives output register.
// - in cascade, only the read enabled device drives the data pins.
// - writes when full and reads when empty change nothing.
// - read attempt on empty keeps last valid word on outputs.
// - dual pin sampled during reset: high dual enable, low offset load.
// - programmable mode: enable1 alone writes, independent of reads.
// - load and enable1 low write offsets in four-register order, wrapping.
// - sequence position kept when load returns high.
// - load and read enables low read offsets in same order.
// - almost empty low at count up to n, high above, read clocked.
// - almost full low at count at least depth minus m, write clocked.
// - both offsets default to seven.
// - array holds depth words of nine bits, separate pointers.
// - empty low only at zero, full low only at full depth.
// - full flag moves on write edges only, empty on read edges only.
module dcf_fifo
    import dcf_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic WRITE_CLK_I,
    input wire logic READ_CLK_I,
    input wire logic [DATA_W-1:0] WRITE_DATA_I,
    input wire logic WRITE_ENABLE_PRIMARY_N_I,
    input wire logic WRITE_ENABLE_SECOND_OR_OFFSET_LOAD_I,
    input wire logic READ_ENABLE_A_N_I,
    input wire logic READ_ENABLE_B_N_I,
    input wire logic OUTPUT_ENABLE_N_I,
    input wire logic CASCADE_MODE_I,
    output logic [DATA_W-1:0] READ_DATA_O,
    output logic READ_DATA_OE_O,
    output logic EMPTY_FLAG_N_O,
    output logic FULL_FLAG_N_O,
    output logic ALMOST_EMPTY_FLAG_N_O,
    output logic ALMOST_FULL_FLAG_N_O
);

    dcf_state_t s_ff;
    dcf_state_t nxt_s;
    dcf_strap_t strap_ff;
    dcf_strap_t nxt_strap;

    logic wr_edge;
    logic rd_edge;
    logic ld_low;
    logic fifo_wr;
    logic fifo_rd;
    logic ofs_wr;
    logic ofs_rd;
    logic rd_both;
    logic [CNT_W-1:0] cnt_nxt;
    logic [OFS_W-1:0] empty_n;
    logic [OFS_W-1:0] full_m;
    logic [DATA_W-1:0] ram_q;

    function automatic logic [DATA_W-1:0] mask_ofs(input logic [1:0] idx,
                                                   input logic [DATA_W-1:0] val);
        logic [DATA_W-1:0] res;
        res = val;
        // upper halves hold only the bits that fit the depth
        if (idx[0]) begin
            res = {{(DATA_W-OFS_HI_W){1'b0}}, val[OFS_HI_W-1:0]};
        end
        return res;
    endfunction

    // strap capture runs unreset so it can watch the pin while reset is low
    always_comb begin
        nxt_strap = strap_ff;
        nxt_strap.s1 = WRITE_ENABLE_SECOND_OR_OFFSET_LOAD_I;
        nxt_strap.s2 = strap_ff.s1;
        if (!RST_N_I) begin
            nxt_strap.mode = strap_ff.s2 ? MODE_DUAL_WE : MODE_PROG_FLAGS;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        strap_ff <= nxt_strap;
    end

    // decode of sampled pin activity
    always_comb begin
        wr_edge = s_ff.s2.wclk & ~s_ff.wclk_d;
        rd_edge = s_ff.s2.rclk & ~s_ff.rclk_d;
        ld_low = (strap_ff.mode == MODE_PROG_FLAGS) & ~s_ff.s2.we2_ld;
        rd_both = ~s_ff.s2.ren_a_n & ~s_ff.s2.ren_b_n;
        // pin is enable2 in dual mode and load-high in programmable mode
        fifo_wr = wr_edge & ~s_ff.s2.we1_n & s_ff.s2.we2_ld & s_ff.ff;
        ofs_wr = wr_edge & ~s_ff.s2.we1_n & ld_low;
        fifo_rd = rd_edge & rd_both & s_ff.ef & ~ld_low;
        ofs_rd = rd_edge & rd_both & ld_low;
        empty_n = {s_ff.ofs[SEQ_EMPTY_HI][OFS_HI_W-1:0], s_ff.ofs[SEQ_EMPTY_LO]};
        full_m = {s_ff.ofs[SEQ_FULL_HI][OFS_HI_W-1:0], s_ff.ofs[SEQ_FULL_LO]};
    end

    always_comb begin
        nxt_s = s_ff;
        // every pin passes two flops; wclk and rclk are only edge-detected
        nxt_s.s1.wclk = WRITE_CLK_I;
        nxt_s.s1.rclk = READ_CLK_I;
        nxt_s.s1.wdata = WRITE_DATA_I;
        nxt_s.s1.we1_n = WRITE_ENABLE_PRIMARY_N_I;
        nxt_s.s1.we2_ld = WRITE_ENABLE_SECOND_OR_OFFSET_LOAD_I;
        nxt_s.s1.ren_a_n = READ_ENABLE_A_N_I;
        nxt_s.s1.ren_b_n = READ_ENABLE_B_N_I;
        nxt_s.s1.oe_n = OUTPUT_ENABLE_N_I;
        nxt_s.s1.cascade = CASCADE_MODE_I;
        nxt_s.s2 = s_ff.s1;
        nxt_s.wclk_d = s_ff.s2.wclk;
        nxt_s.rclk_d = s_ff.s2.rclk;

        if (fifo_wr) begin
            nxt_s.wptr = s_ff.wptr + 15'h0001;
        end
        if (fifo_rd) begin
            nxt_s.rptr = s_ff.rptr + 15'h0001;
        end

        // one shared position; a same-cycle write and read step it once
        if (ofs_wr) begin
            nxt_s.ofs[s_ff.seq] = mask_ofs(s_ff.seq, s_ff.s2.wdata);
        end
        if (ofs_wr | ofs_rd) begin
            nxt_s.seq = s_ff.seq + 2'h1;
        end

        // ram answers one cycle after the read strobe
        nxt_s.rd_pend = fifo_rd;
        if (s_ff.rd_pend) begin
            nxt_s.q = ram_q;
        end else if (ofs_rd) begin
            nxt_s.q = s_ff.ofs[s_ff.seq];
        end

        nxt_s.q_oe = ~s_ff.s2.oe_n & (~s_ff.s2.cascade | rd_both);

        cnt_nxt = nxt_s.wptr - nxt_s.rptr;
        // flags see the count after this edge's own transfer
        if (rd_edge) begin
            nxt_s.ef = (cnt_nxt != '0);
            nxt_s.almost_empty_flag_n = (cnt_nxt > {1'b0, empty_n});
        end
        if (wr_edge) begin
            nxt_s.ff = (cnt_nxt != DEPTH_CNT);
            nxt_s.almost_full_flag_n = (cnt_nxt < (DEPTH_CNT - {1'b0, full_m}));
        end
    end

    // reset constant holds offsets at seven and flags at empty
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s_ff <= ST_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    dcf_ram u_ram (
        .clk_i(CLK_SYS_I),
        .wr_en_i(fifo_wr),
        .wr_addr_i(s_ff.wptr[ADDR_W-1:0]),
        .wr_data_i(s_ff.s2.wdata),
        .rd_en_i(fifo_rd),
        .rd_addr_i(s_ff.rptr[ADDR_W-1:0]),
        .rd_data_o(ram_q)
    );

    assign READ_DATA_O = s_ff.q;
    assign READ_DATA_OE_O = s_ff.q_oe;
    assign EMPTY_FLAG_N_O = s_ff.ef;
    assign FULL_FLAG_N_O = s_ff.ff;
    assign ALMOST_EMPTY_FLAG_N_O = s_ff.almost_empty_flag_n;
    assign ALMOST_FULL_FLAG_N_O = s_ff.almost_full_flag_n;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_N_I);

    a_reset_empty_flags: assert property (
        $rose(RST_N_I) |-> (!EMPTY_FLAG_N_O && FULL_FLAG_N_O && !ALMOST_EMPTY_FLAG_N_O)
    ) else $error("flags not at empty state after reset");

    a_reset_data_low: assert property (
        $rose(RST_N_I) |-> (READ_DATA_O == 9'h000)
    ) else $error("data outputs not low after reset");

    a_dual_write_ptr: assert property (
        fifo_wr |=> (s_ff.wptr == CNT_W'($past(s_ff.wptr) + 15'h0001))
    ) else $error("write pointer did not advance on write");

    a_read_data_out: assert property (
        fifo_rd |=> ##1 (READ_DATA_O == $past(ram_q))
    ) else $error("read word not presented two cycles after read");

    a_oe_floats: assert property (
        s_ff.s2.oe_n |=> !READ_DATA_OE_O
    ) else $error("data driven while output enable high");

    a_cascade_drive: assert property (
        (s_ff.s2.cascade && !rd_both) |=> !READ_DATA_OE_O
    ) else $error("cascaded device drives while not read enabled");

    a_full_no_write: assert property (
        !FULL_FLAG_N_O |=> $stable(s_ff.wptr)
    ) else $error("write pointer moved while full");

    a_empty_no_read: assert property (
        !EMPTY_FLAG_N_O |=> $stable(s_ff.rptr) [*2]
    ) else $error("read pointer moved while empty");

    a_empty_hold_data: assert property (
        (rd_edge && !s_ff.ef && !ld_low && !s_ff.rd_pend) |=> $stable(READ_DATA_O) [*2]
    ) else $error("outputs changed on read of empty fifo");

    a_offset_seq_step: assert property (
        (ofs_wr || ofs_rd) |=> (s_ff.seq == 2'($past(s_ff.seq) + 2'h1))
    ) else $error("offset sequence did not step");

    a_offset_read_out: assert property (
        ofs_rd |=> (READ_DATA_O == $past(s_ff.ofs[s_ff.seq]))
    ) else $error("offset register not shown on outputs");

    a_almost_empty_lvl: assert property (
        rd_edge |=> (ALMOST_EMPTY_FLAG_N_O == ($past(cnt_nxt) > {1'b0, $past(empty_n)}))
    ) else $error("almost empty flag wrong for count");

    a_almost_full_lvl: assert property (
        wr_edge |=> (ALMOST_FULL_FLAG_N_O ==
                     ($past(cnt_nxt) < (DEPTH_CNT - {1'b0, $past(full_m)})))
    ) else $error("almost full flag wrong for count");

    a_empty_flag_lvl: assert property (
        rd_edge |=> (EMPTY_FLAG_N_O == ($past(cnt_nxt) != 15'h0000))
    ) else $error("empty flag wrong for count");

    a_full_flag_lvl: assert property (
        wr_edge |=> (FULL_FLAG_N_O == ($past(cnt_nxt) != DEPTH_CNT))
    ) else $error("full flag wrong for count");

    a_flag_edge_only: assert property (
        (!rd_edge && !wr_edge) |=> ($stable(EMPTY_FLAG_N_O) && $stable(FULL_FLAG_N_O))
    ) else $error("flag moved without its clock edge");

    // each flag may only move on the edge of its own clock
    a_full_write_only: assert property (
        !wr_edge |=> $stable(FULL_FLAG_N_O)
    ) else $error("full flag moved without a write edge");

    a_empty_read_only: assert property (
        !rd_edge |=> $stable(EMPTY_FLAG_N_O)
    ) else $error("empty flag moved without a read edge");

    a_pae_read_only: assert property (
        !rd_edge |=> $stable(ALMOST_EMPTY_FLAG_N_O)
    ) else $error("almost empty flag moved without a read edge");

    a_paf_write_only: assert property (
        !wr_edge |=> $stable(ALMOST_FULL_FLAG_N_O)
    ) else $error("almost full flag moved without a write edge");

    a_dual_we2_low: assert property (
        (wr_edge && strap_ff.mode == MODE_DUAL_WE && !s_ff.s2.we2_ld) |=> $stable(s_ff.wptr)
    ) else $error("write taken with second enable low");

    a_fifo_write_step: assert property (
        (wr_edge && !s_ff.s2.we1_n && s_ff.s2.we2_ld && s_ff.ff) |=>
            (s_ff.wptr == CNT_W'($past(s_ff.wptr) + 15'h0001))
    ) else $error("enabled write not stored");

    a_we1_high_idle: assert property (
        (wr_edge && s_ff.s2.we1_n) |=> ($stable(s_ff.wptr) && $stable(s_ff.ofs))
    ) else $error("write clock stored data with enable high");

    a_wptr_only_write: assert property (
        !fifo_wr |=> $stable(s_ff.wptr)
    ) else $error("write pointer moved without a write");

    a_rptr_only_read: assert property (
        !fifo_rd |=> $stable(s_ff.rptr)
    ) else $error("read pointer moved without a read");

    a_read_ptr_step: assert property (
        fifo_rd |=> (s_ff.rptr == CNT_W'($past(s_ff.rptr) + 15'h0001))
    ) else $error("read pointer did not advance on read");

    a_read_pending: assert property (
        fifo_rd |=> s_ff.rd_pend
    ) else $error("read not followed by output load");

    a_empty_no_fetch: assert property (
        (rd_edge && !s_ff.ef) |=> !s_ff.rd_pend
    ) else $error("array read while empty");

    a_data_hold_idle: assert property (
        (!s_ff.rd_pend && !ofs_rd) |=> $stable(READ_DATA_O)
    ) else $error("outputs changed without a read");

    a_count_in_range: assert property (
        (CNT_W'(s_ff.wptr - s_ff.rptr) <= DEPTH_CNT)
    ) else $error("word count beyond array depth");

    // offset accesses must leave the data pointers alone
    a_ofs_write_no_ptr: assert property (
        ofs_wr |=> $stable(s_ff.wptr)
    ) else $error("offset write moved the write pointer");

    a_ofs_read_no_ptr: assert property (
        ofs_rd |=> $stable(s_ff.rptr)
    ) else $error("offset read moved the read pointer");

    a_ofs_empty_lo: assert property (
        (ofs_wr && s_ff.seq == SEQ_EMPTY_LO) |=> (s_ff.ofs[SEQ_EMPTY_LO] == $past(s_ff.s2.wdata))
    ) else $error("empty offset low not stored");

    a_ofs_full_lo: assert property (
        (ofs_wr && s_ff.seq == SEQ_FULL_LO) |=> (s_ff.ofs[SEQ_FULL_LO] == $past(s_ff.s2.wdata))
    ) else $error("full offset low not stored");

    a_ofs_empty_hi: assert property (
        (ofs_wr && s_ff.seq == SEQ_EMPTY_HI) |=>
            (s_ff.ofs[SEQ_EMPTY_HI][OFS_HI_W-1:0] == $past(s_ff.s2.wdata[OFS_HI_W-1:0]))
    ) else $error("empty offset high not stored");

    a_ofs_full_hi: assert property (
        (ofs_wr && s_ff.seq == SEQ_FULL_HI) |=>
            (s_ff.ofs[SEQ_FULL_HI][OFS_HI_W-1:0] == $past(s_ff.s2.wdata[OFS_HI_W-1:0]))
    ) else $error("full offset high not stored");

    a_ofs_seq_hold: assert property (
        !ld_low |=> $stable(s_ff.seq)
    ) else $error("offset position moved with load high");

    // mode is only taken while reset is low
    a_mode_run_stable: assert property (
        RST_N_I |=> $stable(strap_ff.mode)
    ) else $error("mode changed outside reset");

    a_oe_drives: assert property (
        (!s_ff.s2.oe_n && !s_ff.s2.cascade) |=> READ_DATA_OE_O
    ) else $error("data not driven while output enable low");

    a_cascade_enabled: assert property (
        (!s_ff.s2.oe_n && rd_both) |=> READ_DATA_OE_O
    ) else $error("read enabled device does not drive");

endmodule

// ===== dcf_pkg.sv
// shared constants and types for the dual clock fifo with programmable flags
package dcf_pkg;

    localparam int DATA_W = 9;
    localparam int DEPTH = 16384;
    localparam int ADDR_W = 14;
    localparam int CNT_W = 15;
    localparam int OFS_W = 14;
    localparam int OFS_HI_W = OFS_W - DATA_W;
    localparam logic [CNT_W-1:0] DEPTH_CNT = 15'h4000;

    // offset register sequence positions
    localparam logic [1:0] SEQ_EMPTY_LO = 2'h0;
    localparam logic [1:0] SEQ_EMPTY_HI = 2'h1;
    localparam logic [1:0] SEQ_FULL_LO = 2'h2;
    localparam logic [1:0] SEQ_FULL_HI = 2'h3;

    // reset values
    localparam logic [DATA_W-1:0] OFS_LO_RST = 9'h007;
    localparam logic [DATA_W-1:0] OFS_HI_RST = 9'h000;
    localparam logic EF_RST = 1'b0;
    localparam logic FF_RST = 1'b1;
    localparam logic PAE_RST = 1'b0;
    localparam logic PAF_RST = 1'b1;

    typedef enum logic {
        MODE_PROG_FLAGS,
        MODE_DUAL_WE
    } dcf_mode_t;

    typedef struct packed {
        logic wclk;
        logic rclk;
        logic [DATA_W-1:0] wdata;
        logic we1_n;
        logic we2_ld;
        logic ren_a_n;
        logic ren_b_n;
        logic oe_n;
        logic cascade;
    } dcf_pins_t;

    typedef struct packed {
        dcf_pins_t s1;
        dcf_pins_t s2;
        logic wclk_d;
        logic rclk_d;
        logic [CNT_W-1:0] wptr;
        logic [CNT_W-1:0] rptr;
        logic [1:0] seq;
        logic [3:0][DATA_W-1:0] ofs;
        logic rd_pend;
        logic [DATA_W-1:0] q;
        logic q_oe;
        logic ef;
        logic ff;
        logic almost_empty_flag_n;
        logic almost_full_flag_n;
    } dcf_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        dcf_mode_t mode;
    } dcf_strap_t;

    localparam dcf_pins_t PINS_RST = '{wclk: 1'b1, rclk: 1'b1, we1_n: 1'b1, we2_ld: 1'b1,
        ren_a_n: 1'b1, ren_b_n: 1'b1, oe_n: 1'b1, default: '0};

    localparam dcf_state_t ST_RST = '{s1: PINS_RST, s2: PINS_RST, wclk_d: 1'b1,
        rclk_d: 1'b1, ofs: {OFS_HI_RST, OFS_LO_RST, OFS_HI_RST, OFS_LO_RST},
        ef: EF_RST, ff: FF_RST, almost_empty_flag_n: PAE_RST, almost_full_flag_n: PAF_RST, default: '0};

endpackage

// ===== dcf_ram.sv
// storage array with one write port and one registered read port
`timescale 1ns/1ps
module dcf_ram
    import dcf_pkg::*;
(
    input wire logic clk_i,
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [DATA_W-1:0] rd_data_o
);

    logic [DATA_W-1:0] mem [DEPTH];

    // no reset on the array so it maps onto block ram
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i) begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule

// ===== dcf_peer.sv
// writer and reader logic on the far side of the fifo pins
`timescale 1ns/1ps
module dcf_peer
    import dcf_pkg::*;
(
    input wire logic clk_i,
    output logic wclk_o,
    output logic rclk_o,
    output logic [DATA_W-1:0] wdata_o,
    output logic we1_n_o,
    output logic we2_ld_o,
    output logic ren_n_o
);
    initial begin
        wclk_o = 1'b1;
        rclk_o = 1'b1;
        wdata_o = '0;
        we1_n_o = 1'b1;
        we2_ld_o = 1'b1;
        ren_n_o = 1'b1;
    end
    task automatic strap(input logic v);
        @(posedge clk_i);
        we2_ld_o <= v;
    endtask
    // one op per frame; both clocks stand high between frames
    task automatic op(input logic wr, input logic en, input logic ld,
                      input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        we2_ld_o <= ld;
        wdata_o <= d;
        if (wr) begin
            we1_n_o <= ~en;
            wclk_o <= 1'b0;
        end else begin
            ren_n_o <= ~en;
            rclk_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        wclk_o <= 1'b1;
        rclk_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        // released bus must not keep showing the old word
        wdata_o <= ~d;
        we1_n_o <= 1'b1;
        ren_n_o <= 1'b1;
    endtask
endmodule

// ===== dcf_fifo_tb.sv
// self-checking bench for the dual clock fifo
`timescale 1ns/1ps
module dcf_fifo_tb
    import dcf_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic oe_n = 1'b1;
    logic casc = 1'b0;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    logic wclk, rclk, we1_n, we2_ld, ren_n, oe, ef, ff, almost_empty_flag_n, almost_full_flag_n;
    logic [DATA_W-1:0] wdata, q;
    wire logic [DATA_W-1:0] qbus;
    wire logic [DATA_W-1:0] flg = {5'h00, ef, ff, almost_empty_flag_n, almost_full_flag_n};
    assign qbus = oe ? q : 9'hzzz;

    initial begin
        forever #20 clk = ~clk;
    end

    dcf_peer peer (.clk_i(clk), .wclk_o(wclk), .rclk_o(rclk), .wdata_o(wdata),
        .we1_n_o(we1_n), .we2_ld_o(we2_ld), .ren_n_o(ren_n));

    dcf_fifo DUT (.CLK_SYS_I(clk), .RST_N_I(rst_n), .WRITE_CLK_I(wclk),
        .READ_CLK_I(rclk), .WRITE_DATA_I(wdata), .WRITE_ENABLE_PRIMARY_N_I(we1_n),
        .WRITE_ENABLE_SECOND_OR_OFFSET_LOAD_I(we2_ld), .READ_ENABLE_A_N_I(ren_n),
        .READ_ENABLE_B_N_I(ren_n), .OUTPUT_ENABLE_N_I(oe_n), .CASCADE_MODE_I(casc),
        .READ_DATA_O(q), .READ_DATA_OE_O(oe), .EMPTY_FLAG_N_O(ef),
        .FULL_FLAG_N_O(ff), .ALMOST_EMPTY_FLAG_N_O(almost_empty_flag_n), .ALMOST_FULL_FLAG_N_O(almost_full_flag_n));

    task automatic give_verdict();
        $display("tests %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // strap settles through the unreset sync flops while reset is low
    task automatic do_reset(input logic s);
        peer.strap(s);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check(flg, 9'h005);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(q, 9'h000);
    endtask

    task automatic rd(input logic [DATA_W-1:0] eq, input logic [DATA_W-1:0] ef_exp);
        peer.op(1'b0, 1'b1, 1'b1, '0);
        #1;
        check(q, eq);
        check(flg, ef_exp);
    endtask

    task automatic t_prog();
        logic [DATA_W-1:0] dflt [4] = '{9'h007, 9'h000, 9'h007, 9'h000};
        logic [DATA_W-1:0] val [4] = '{9'h002, 9'h000, 9'h003, 9'h000};
        do_reset(1'b0);
        for (int i = 0; i < 4; i++) begin
            peer.op(1'b0, 1'b1, 1'b0, '0);
            #1;
            check(q, dflt[i]);
        end
        for (int i = 0; i < 4; i++) begin
            if (i == 2) begin
                peer.op(1'b1, 1'b0, 1'b1, 9'h1ff);
            end
            peer.op(1'b1, 1'b1, 1'b0, val[i]);
        end
        for (int i = 0; i < 4; i++) begin
            peer.op(1'b0, 1'b1, 1'b0, '0);
            #1;
            check(q, val[i]);
        end
    endtask

    // offsets now n=2 and m=3
    task automatic t_fifo();
        logic [DATA_W-1:0] wd [3] = '{9'h1a5, 9'h05a, 9'h1ff};
        logic [DATA_W-1:0] fl [3] = '{9'h00d, 9'h00d, 9'h005};
        for (int i = 0; i < 3; i++) begin
            peer.op(1'b1, 1'b1, 1'b1, wd[i]);
        end
        peer.op(1'b0, 1'b0, 1'b1, '0);
        #1;
        check(flg, 9'h00f);
        for (int i = 0; i < 3; i++) begin
            rd(wd[i], fl[i]);
        end
        rd(wd[2], 9'h005);
    endtask

    task automatic t_dual();
        do_reset(1'b1);
        peer.op(1'b1, 1'b1, 1'b0, 9'h055);
        peer.op(1'b1, 1'b1, 1'b1, 9'h0aa);
        peer.op(1'b0, 1'b0, 1'b1, '0);
        rd(9'h0aa, 9'h005);
    endtask

    task automatic t_oe();
        @(posedge clk);
        oe_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check(qbus, 9'h0aa);
        @(posedge clk);
        casc <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check(qbus, 9'hzzz);
        @(posedge clk);
        casc <= 1'b0;
        oe_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check(qbus, 9'hzzz);
    endtask

    // about 25 link frames of 9 cycles plus resets, far below this ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        t_prog();
        t_fifo();
        t_dual();
        t_oe();
        give_verdict();
    end
endmodule
